// file: src/rtc_trim_pkg.sv
// constants, register map and state types for the trim and failure-flag block
// Overview of operation
// - once per 20 seconds, change the second length
// - codes 0, +1, -64, -63 correct nothing
// - seven-bit signed code, gain from 01h, loss from 80h
// - codes 02h..3Fh slow the count in steps
// - codes 7Fh..42h speed the count in steps
// - reference clock output never sees the trim
// - halt and supply flags stick until written 0
// - supply below selected threshold sets supply flag
// - halt flag rising forces supply flag to 0
// - halt sensing only while chip enable low
// - halt flag rising clears trim and control bits
// - power-up sets the halt flag
// - supply sampled 7.8 ms once per second
// - supply sampling stops while supply flag set
package rtc_trim_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
    localparam int unsigned SAMPLE_TIME_US = 7800;
    localparam int unsigned SAMPLE_CYCLES = SAMPLE_TIME_US * CLK_PER_US;
    // no oscillator edge for this long counts as a halt
    localparam int unsigned HALT_TIME_US = 1000;
    localparam int unsigned HALT_CYCLES = HALT_TIME_US * CLK_PER_US;
    localparam int CNT_W = 20;
    localparam logic [16:0] OSC_PER_SEC = 17'h08000;
    localparam logic [4:0] TRIM_SEC_LAST = 5'h13;
    // ************************************************************
    // trim code
    // ************************************************************
    localparam int TRIM_W = 7;
    localparam int TRIM_SIGN_BIT = 6;
    localparam logic [6:0] TRIM_GAIN_BASE = 7'h01;
    localparam logic [7:0] TRIM_LOSS_BASE = 8'h80;
    localparam logic [6:0] TRIM_LOSS_MIN = 7'h42;
    // ************************************************************
    // register map: index, byte address is four times it
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [3:0] REG_TRIM_IDX = 4'h7;
    localparam logic [3:0] REG_CTRL1_IDX = 4'he;
    localparam logic [3:0] REG_CTRL2_IDX = 4'hf;
    localparam logic [11:0] REG_TRIM_ADDR = {6'h00, REG_TRIM_IDX, 2'h0};
    localparam logic [11:0] REG_CTRL1_ADDR = {6'h00, REG_CTRL1_IDX, 2'h0};
    localparam logic [11:0] REG_CTRL2_ADDR = {6'h00, REG_CTRL2_IDX, 2'h0};
    // control 1 fields
    localparam int C1_WEEKLY_ALARM_EN = 7;
    localparam int C1_DAILY_ALARM_EN = 6;
    localparam int C1_HOUR24_SEL = 5;
    localparam int C1_CLKOUT_EN_B_N = 4;
    localparam int C1_TEST = 3;
    localparam int C1_PERIODIC_SEL_2 = 2;
    localparam int C1_PERIODIC_SEL_1 = 1;
    localparam int C1_PERIODIC_SEL_0 = 0;
    // control 2 fields
    localparam int C2_THRESHOLD_SEL = 7;
    localparam int C2_SUPPLY_DROP = 6;
    localparam int C2_OSC_HALT = 5;
    localparam int C2_CLKOUT_EN_A_N = 4;
    localparam int C2_SCRATCH = 3;
    localparam int C2_PERIODIC_FLAG = 2;
    localparam int C2_WEEKLY_ALARM_FLAG = 1;
    localparam int C2_DAILY_ALARM_FLAG = 0;
    // flags that software may only clear by writing 0
    localparam logic [7:0] C2_FLAG_MASK = 8'h67;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h20;
    localparam logic [6:0] TRIM_RESET = 7'h00;
    // ************************************************************
    // supply monitor states
    // ************************************************************
    typedef enum logic [1:0] {
        MON_WAIT = 2'b01,
        MON_SAMPLE = 2'b10
    } mon_state_t;
endpackage : rtc_trim_pkg

// file: src/rtc_pin_filter.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rtc_pin_filter #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and filtered levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } filt_t;

    filt_t f_q;
    filt_t f_d;

    always_comb begin
        f_d = f_q;
        f_d.s1 = pin_in;
        f_d.s2 = f_q.s1;
        f_d.s3 = f_q.s2;
        // a change counts only once two late stages agree
        for (int i = 0; i < W; i++) begin
            if (f_q.s2[i] == f_q.s3[i]) begin
                f_d.lvl[i] = f_q.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    assign level_out = f_q.lvl;
endmodule : rtc_pin_filter

// file: src/rtc_trim_and_fail_flags.sv
// trim of the seconds count, oscillator halt and supply drop flags, apb registers
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rtc_trim_and_fail_flags #(
    parameter int unsigned SAMPLE_LEN = rtc_trim_pkg::SAMPLE_CYCLES,
    parameter int unsigned HALT_LEN = rtc_trim_pkg::HALT_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic osc_in,
    input wire logic ce_in,
    input wire logic supply_below_hi,
    input wire logic supply_below_lo,
    // events from alarm and periodic logic
    input wire logic weekly_alarm_event,
    input wire logic daily_alarm_event,
    input wire logic periodic_event,
    // outputs
    output logic ref_clock_out,
    output logic sec_tick,
    output logic osc_halt_flag,
    output logic supply_drop_flag
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic osc_prev;
        logic [16:0] osc_cnt;
        logic [4:0] sec_idx;
        logic sec_tick;
        logic ref_clk;
        logic [rtc_trim_pkg::CNT_W-1:0] idle_cnt;
        rtc_trim_pkg::mon_state_t mon;
        logic [rtc_trim_pkg::CNT_W-1:0] mon_cnt;
        logic [6:0] trim;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    localparam state_t RESET_STATE = '{
        osc_prev: 1'b0,
        osc_cnt: 17'h00000,
        sec_idx: 5'h00,
        sec_tick: 1'b0,
        ref_clk: 1'b0,
        idle_cnt: '0,
        mon: rtc_trim_pkg::MON_WAIT,
        mon_cnt: '0,
        trim: rtc_trim_pkg::TRIM_RESET,
        ctrl1: rtc_trim_pkg::CTRL1_RESET,
        ctrl2: rtc_trim_pkg::CTRL2_RESET,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h00000000
    };

    localparam logic [rtc_trim_pkg::CNT_W-1:0] HALT_LAST =
        rtc_trim_pkg::CNT_W'(HALT_LEN - 1);
    localparam logic [rtc_trim_pkg::CNT_W-1:0] SAMPLE_LAST =
        rtc_trim_pkg::CNT_W'(SAMPLE_LEN - 1);

    state_t s_q;
    state_t s_d;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [3:0] pin_lvl;

    rtc_pin_filter #(
        .W(4)
    ) u_pins (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({supply_below_lo, supply_below_hi, ce_in, osc_in}),
        .level_out(pin_lvl)
    );

    logic osc_lvl;
    logic ce_lvl;
    logic below_hi_lvl;
    logic below_lo_lvl;

    assign osc_lvl = pin_lvl[0];
    assign ce_lvl = pin_lvl[1];
    assign below_hi_lvl = pin_lvl[2];
    assign below_lo_lvl = pin_lvl[3];

    // ************************************************************
    // next state
    // ************************************************************
    logic osc_rise;
    logic osc_change;
    logic [6:0] steps;
    logic lengthen;
    logic shorten;
    logic [7:0] delta;
    logic [16:0] sec_len;
    logic halt_set;
    logic below;
    logic acc_start;
    logic acc_done;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] flag_set;

    always_comb begin
        s_d = s_q;
        osc_change = osc_lvl ^ s_q.osc_prev;
        osc_rise = osc_lvl & ~s_q.osc_prev;
        s_d.osc_prev = osc_lvl;
        // filtered oscillator level, no trim applied
        s_d.ref_clk = osc_lvl;

        // correction size from the signed code
        steps = 7'h00;
        lengthen = 1'b0;
        shorten = 1'b0;
        if (!s_q.trim[rtc_trim_pkg::TRIM_SIGN_BIT]) begin
            if (s_q.trim > rtc_trim_pkg::TRIM_GAIN_BASE) begin
                lengthen = 1'b1;
                steps = s_q.trim - rtc_trim_pkg::TRIM_GAIN_BASE;
            end
        end else begin
            if (s_q.trim >= rtc_trim_pkg::TRIM_LOSS_MIN) begin
                shorten = 1'b1;
                steps = 7'(rtc_trim_pkg::TRIM_LOSS_BASE - {1'b0, s_q.trim});
            end
        end
        delta = {steps, 1'b0};
        sec_len = rtc_trim_pkg::OSC_PER_SEC;
        if (s_q.sec_idx == rtc_trim_pkg::TRIM_SEC_LAST) begin
            if (lengthen) begin
                sec_len = rtc_trim_pkg::OSC_PER_SEC + 17'(delta);
            end else if (shorten) begin
                sec_len = rtc_trim_pkg::OSC_PER_SEC - 17'(delta);
            end
        end

        // prescaler counts rising oscillator edges
        s_d.sec_tick = 1'b0;
        if (osc_rise) begin
            if (s_q.osc_cnt == sec_len - 17'h00001) begin
                s_d.osc_cnt = 17'h00000;
                s_d.sec_tick = 1'b1;
                if (s_q.sec_idx == rtc_trim_pkg::TRIM_SEC_LAST) begin
                    s_d.sec_idx = 5'h00;
                end else begin
                    s_d.sec_idx = s_q.sec_idx + 5'h01;
                end
            end else begin
                s_d.osc_cnt = s_q.osc_cnt + 17'h00001;
            end
        end

        // halt sensing: idle time since the last oscillator edge
        if (osc_change) begin
            s_d.idle_cnt = '0;
        end else if (s_q.idle_cnt != HALT_LAST) begin
            s_d.idle_cnt = s_q.idle_cnt + rtc_trim_pkg::CNT_W'(1);
        end
        // result frozen while chip enable is high
        halt_set = (s_q.idle_cnt == HALT_LAST) && !ce_lvl
            && !s_q.ctrl2[rtc_trim_pkg::C2_OSC_HALT];

        // supply monitor window
        below = s_q.ctrl2[rtc_trim_pkg::C2_THRESHOLD_SEL] ? below_lo_lvl : below_hi_lvl;
        flag_set = 8'h00;
        unique case (s_q.mon)
            rtc_trim_pkg::MON_WAIT: begin
                // no sampling while the flag is up
                if (s_q.sec_tick && !s_q.ctrl2[rtc_trim_pkg::C2_SUPPLY_DROP]) begin
                    s_d.mon = rtc_trim_pkg::MON_SAMPLE;
                    s_d.mon_cnt = '0;
                end
            end
            rtc_trim_pkg::MON_SAMPLE: begin
                if (below) begin
                    flag_set[rtc_trim_pkg::C2_SUPPLY_DROP] = 1'b1;
                end
                if (s_q.ctrl2[rtc_trim_pkg::C2_SUPPLY_DROP]) begin
                    s_d.mon = rtc_trim_pkg::MON_WAIT;
                end else if (s_q.mon_cnt == SAMPLE_LAST) begin
                    s_d.mon = rtc_trim_pkg::MON_WAIT;
                end else begin
                    s_d.mon_cnt = s_q.mon_cnt + rtc_trim_pkg::CNT_W'(1);
                end
            end
            default: begin
                s_d.mon = rtc_trim_pkg::MON_WAIT;
            end
        endcase
        flag_set[rtc_trim_pkg::C2_WEEKLY_ALARM_FLAG] = weekly_alarm_event;
        flag_set[rtc_trim_pkg::C2_DAILY_ALARM_FLAG] = daily_alarm_event;
        flag_set[rtc_trim_pkg::C2_PERIODIC_FLAG] = periodic_event;

        // apb: answer one cycle into the access phase
        acc_start = psel && penable && !s_q.pready;
        acc_done = psel && penable && s_q.pready;
        wr = acc_done && pwrite;
        wbyte = pwdata[7:0];
        s_d.pready = acc_start;
        s_d.pslverr = 1'b0;
        if (acc_start) begin
            s_d.prdata = 32'h00000000;
            unique case (paddr)
                rtc_trim_pkg::REG_TRIM_ADDR: s_d.prdata = {25'h0000000, s_q.trim};
                rtc_trim_pkg::REG_CTRL1_ADDR: s_d.prdata = {24'h000000, s_q.ctrl1};
                rtc_trim_pkg::REG_CTRL2_ADDR: s_d.prdata = {24'h000000, s_q.ctrl2};
                default: s_d.pslverr = 1'b1;
            endcase
        end

        if (wr && paddr == rtc_trim_pkg::REG_TRIM_ADDR) begin
            s_d.trim = wbyte[6:0];
        end
        if (wr && paddr == rtc_trim_pkg::REG_CTRL1_ADDR) begin
            s_d.ctrl1 = wbyte;
        end
        if (wr && paddr == rtc_trim_pkg::REG_CTRL2_ADDR) begin
            // flags only clear on 0, writing 1 leaves them alone
            s_d.ctrl2 = (wbyte & ~rtc_trim_pkg::C2_FLAG_MASK)
                | (s_q.ctrl2 & wbyte & rtc_trim_pkg::C2_FLAG_MASK);
        end
        // a set in the same cycle as a clear wins
        s_d.ctrl2 = s_d.ctrl2 | flag_set;

        if (halt_set) begin
            s_d.trim = rtc_trim_pkg::TRIM_RESET;
            s_d.ctrl1 = 8'h00;
            s_d.ctrl2 = 8'h00;
            s_d.ctrl2[rtc_trim_pkg::C2_OSC_HALT] = 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // reset stands for power-up: halt flag reads 1 afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign ref_clock_out = s_q.ref_clk;
    assign sec_tick = s_q.sec_tick;
    assign osc_halt_flag = s_q.ctrl2[rtc_trim_pkg::C2_OSC_HALT];
    assign supply_drop_flag = s_q.ctrl2[rtc_trim_pkg::C2_SUPPLY_DROP];
endmodule : rtc_trim_and_fail_flags

// file: sim/rtc_trim_monitor.sv
// concurrent checks on the ports of the trim and failure-flag block
`timescale 1ns/1ps
module rtc_trim_monitor #(
    parameter int unsigned SAMPLE_LEN = 20,
    parameter int unsigned HALT_LEN = 50
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic osc_in,
    input wire logic ce_in,
    input wire logic supply_below_hi,
    input wire logic supply_below_lo,
    // outputs
    input wire logic ref_clock_out,
    input wire logic sec_tick,
    input wire logic osc_halt_flag,
    input wire logic supply_drop_flag
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_c2;
    assign wr_c2 = psel && penable && pready && pwrite && paddr == rtc_trim_pkg::REG_CTRL2_ADDR;
    AST_HALT_STICKS: assert property (
        osc_halt_flag && !(wr_c2 && !pwdata[5]) |=> osc_halt_flag)
        else $error("halt flag fell without a clearing write");
    AST_DROP_STICKS: assert property (
        supply_drop_flag && !(wr_c2 && !pwdata[6]) |=> supply_drop_flag || $rose(osc_halt_flag))
        else $error("supply flag fell without cause");
    AST_HALT_CLEARS_DROP: assert property ($rose(osc_halt_flag) |-> !supply_drop_flag)
        else $error("supply flag not cleared by halt");
    AST_NO_HALT_CE_HIGH: assert property (ce_in [*8] |=> !$rose(osc_halt_flag))
        else $error("halt sensed while chip enable high");
    AST_DROP_NEEDS_LOW: assert property (
        (!supply_below_hi && !supply_below_lo) [*8] |=> !$rose(supply_drop_flag))
        else $error("supply flag set with supply good");
    AST_REF_FOLLOWS_OSC: assert property ($stable(osc_in) [*8] |=> $stable(ref_clock_out))
        else $error("reference output moved without oscillator");
    AST_TICK_NEEDS_OSC: assert property ($stable(osc_in) [*8] |=> !sec_tick)
        else $error("second tick without oscillator edges");
    AST_POWERUP_HALT: assert property ($rose(presetn) |-> osc_halt_flag)
        else $error("halt flag not set at power-up");
    AST_APB_ANSWER: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    // ************************************************************
    // covers
    // ************************************************************
    COV_HALT_SET: cover property ($rose(osc_halt_flag));
    COV_HALT_CLEAR: cover property ($fell(osc_halt_flag));
    COV_SLVERR: cover property (pready && pslverr);
endmodule : rtc_trim_monitor

bind rtc_trim_and_fail_flags rtc_trim_monitor #(.SAMPLE_LEN(SAMPLE_LEN), .HALT_LEN(HALT_LEN))
    rtc_trim_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .osc_in(osc_in), .ce_in(ce_in), .supply_below_hi(supply_below_hi),
    .supply_below_lo(supply_below_lo), .ref_clock_out(ref_clock_out), .sec_tick(sec_tick),
    .osc_halt_flag(osc_halt_flag), .supply_drop_flag(supply_drop_flag));

// file: sim/rtc_pin_partner.sv
// oscillator and chip-enable pins facing the block
`timescale 1ns/1ps
module rtc_pin_partner #(
    parameter int HALF = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controls
    input wire logic run,
    input wire logic ce_req,
    // pins
    output logic osc_out,
    output logic ce_out
);
    int cnt = 0;
    initial osc_out = 1'b0;
    // a stopped crystal freezes at its last level
    always @(posedge pclk) begin
        if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                osc_out <= !osc_out;
            end
        end
    end
    // chip enable kept low while power comes up
    assign ce_out = presetn ? ce_req : 1'b0;
endmodule : rtc_pin_partner

// file: sim/rtc_trim_and_fail_flags_bench.sv
// self-checking bench for the trim and failure-flag block
`timescale 1ns/1ps
module rtc_trim_and_fail_flags_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic osc_in, ce_in, run, ce_req, sbh, sbl, wev, dev, pev;
    logic ref_clock_out, sec_tick, osc_halt_flag, supply_drop_flag, rerr;
    int err_count = 0;
    int comparisons = 0;
    rtc_trim_and_fail_flags #(.SAMPLE_LEN(20), .HALT_LEN(50)) rtc_trim_and_fail_flags_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_in(osc_in), .ce_in(ce_in), .supply_below_hi(sbh), .supply_below_lo(sbl),
        .weekly_alarm_event(wev), .daily_alarm_event(dev), .periodic_event(pev),
        .ref_clock_out(ref_clock_out), .sec_tick(sec_tick), .osc_halt_flag(osc_halt_flag),
        .supply_drop_flag(supply_drop_flag));
    rtc_pin_partner #(.HALF(4)) rtc_pin_partner_inst (.pclk(pclk), .presetn(presetn),
        .run(run), .ce_req(ce_req), .osc_out(osc_in), .ce_out(ce_in));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // one idle edge first, so a release and a new setup never share a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            $display("BAD %0t no apb answer", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp, "read data");
        chk({31'h0, rerr}, {31'h0, experr}, "slave error");
    endtask : rd
    task automatic t_reset();
        chk({31'h0, osc_halt_flag}, 32'h1, "halt flag at power-up");
        rd(rtc_trim_pkg::REG_CTRL2_ADDR, 32'h20, 1'b0);
        rd(rtc_trim_pkg::REG_TRIM_ADDR, 32'h0, 1'b0);
        rd(rtc_trim_pkg::REG_CTRL1_ADDR, 32'h0, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        apb(1'b1, rtc_trim_pkg::REG_TRIM_ADDR, 32'h57);
        rd(rtc_trim_pkg::REG_TRIM_ADDR, 32'h57, 1'b0);
        apb(1'b1, rtc_trim_pkg::REG_CTRL1_ADDR, 32'hff);
        rd(rtc_trim_pkg::REG_CTRL1_ADDR, 32'hff, 1'b0);
        apb(1'b1, rtc_trim_pkg::REG_CTRL2_ADDR, 32'hff);
        rd(rtc_trim_pkg::REG_CTRL2_ADDR, 32'hb8, 1'b0);
        rd(12'h000, 32'h0, 1'b1);
        apb(1'b1, 12'h004, 32'hff);
        chk({31'h0, rerr}, 32'h1, "unmapped write");
        apb(1'b1, rtc_trim_pkg::REG_CTRL2_ADDR, 32'h18);
        // the write lands on the edge the task returns on, look one edge later
        @(posedge pclk);
        chk({31'h0, osc_halt_flag}, 32'h0, "halt flag cleared");
        @(posedge pclk);
        wev <= 1'b1;
        @(posedge pclk);
        wev <= 1'b0;
        apb(1'b1, rtc_trim_pkg::REG_CTRL2_ADDR, 32'h9a);
        rd(rtc_trim_pkg::REG_CTRL2_ADDR, 32'h9a, 1'b0);
        $display("test registers done");
    endtask : t_regs
    task automatic t_ref();
        int no, nr;
        logic po, pr;
        no = 0;
        nr = 0;
        po = osc_in;
        pr = ref_clock_out;
        apb(1'b1, rtc_trim_pkg::REG_TRIM_ADDR, 32'h7f);
        repeat (200) begin
            @(posedge pclk);
            if (osc_in && !po) no++;
            if (ref_clock_out && !pr) nr++;
            po = osc_in;
            pr = ref_clock_out;
        end
        chk(32'(no - nr <= 1 && nr - no <= 1), 32'h1, "reference edge count");
        $display("test reference done");
    endtask : t_ref
    task automatic t_halt();
        int n;
        n = 0;
        ce_req <= 1'b1;
        repeat (8) @(posedge pclk);
        run <= 1'b0;
        repeat (150) @(posedge pclk);
        chk({31'h0, osc_halt_flag}, 32'h0, "halt while chip enable high");
        ce_req <= 1'b0;
        while (osc_halt_flag !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, osc_halt_flag}, 32'h1, "halt once chip enable low");
        rd(rtc_trim_pkg::REG_TRIM_ADDR, 32'h0, 1'b0);
        rd(rtc_trim_pkg::REG_CTRL1_ADDR, 32'h0, 1'b0);
        rd(rtc_trim_pkg::REG_CTRL2_ADDR, 32'h20, 1'b0);
        run <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b1, rtc_trim_pkg::REG_CTRL2_ADDR, 32'h0);
        repeat (100) @(posedge pclk);
        chk({31'h0, osc_halt_flag}, 32'h0, "halt flag stays clear");
        $display("test halt done");
    endtask : t_halt
    task automatic t_rerun();
        apb(1'b1, rtc_trim_pkg::REG_TRIM_ADDR, 32'h09);
        rd(rtc_trim_pkg::REG_TRIM_ADDR, 32'h09, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, osc_halt_flag}, 32'h1, "halt flag after second reset");
        rd(rtc_trim_pkg::REG_TRIM_ADDR, 32'h0, 1'b0);
        $display("test second reset done");
    endtask : t_rerun
    // ************************************************************
    // clock, watchdog, sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("BAD %0t watchdog ran out", $time);
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sbh, sbl, wev, dev, pev, ce_req} = '0;
        run = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_ref();
        t_halt();
        t_rerun();
        end_of_test();
    end
endmodule : rtc_trim_and_fail_flags_bench
